/* design/bpsc_top.sv */
// Purpose: Strap capture, soft reset gating and output pin state control
// Assumes: Core-side inputs are on ref_clk; pin inputs are asynchronous
// Notes:   Strap pins are resampled every cycle of hard reset; last sample wins
`timescale 1ns/1ps
module bpsc_top #(
	parameter int MGMT_BASE_W = bpsc_pkg::MGMT_BASE_W
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	input  wire logic                    soft_reset_in,
	input  wire logic                    line_policy_sel_n,
	input  wire logic                    core_ratio_sel,
	input  wire logic                    hold,
	input  wire logic                    addr_hold,
	input  wire logic                    snoop_strobe_n,
	input  wire logic                    burst_ready_n,
	input  wire logic                    nonburst_ready_n,
	input  wire bpsc_pkg::bpsc_bus_pins_t core_pins,
	input  wire logic                    core_stop_grant,
	input  wire logic                    core_instr_boundary,
	input  wire logic                    core_line_fill,
	input  wire logic                    snoop_hit,
	input  wire logic                    snoop_hit_modified,
	input  wire logic                    mgmt_base_wr,
	input  wire logic [MGMT_BASE_W-1:0]  mgmt_base_wdata,
	output bpsc_pkg::bpsc_bus_pins_t     pins_out,
	output bpsc_pkg::bpsc_pin_oe_n_t     pins_oe_n,
	output logic                         hold_ack,
	output logic                         low_voltage_ident_n,
	output logic                         copyback_bus_mode,
	output logic [1:0]                   core_clk_mult,
	output logic                         soft_reset_take,
	output logic                         line_policy_valid,
	output logic                         line_write_back,
	output logic [MGMT_BASE_W-1:0]       mgmt_memory_base
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [bpsc_pkg::PIN_COUNT-1:0] pin_raw;
	logic [bpsc_pkg::PIN_COUNT-1:0] pin_s;
	logic                           srst_s;
	logic                           snoop_s;
	logic                           ready_s;
	logic                           soft_serviced;
	logic                           fill_seen;
	bpsc_pkg::bpsc_mode_t           mode;
	bpsc_pkg::bpsc_mode_t           next_mode;

	assign pin_raw = {nonburst_ready_n, burst_ready_n, snoop_strobe_n, addr_hold,
			hold, core_ratio_sel, line_policy_sel_n, soft_reset_in};

	bpsc_sync #(
		.WIDTH (bpsc_pkg::PIN_COUNT)
	) u_sync (
		.ref_clk  (ref_clk),
		.pin_in   (pin_raw),
		.pin_sync (pin_s)
	);

	assign srst_s  = pin_s[bpsc_pkg::IDX_SOFT_RESET];
	assign snoop_s = ~pin_s[bpsc_pkg::IDX_SNOOP_N];
	assign ready_s = ~pin_s[bpsc_pkg::IDX_BURST_RDY_N] | ~pin_s[bpsc_pkg::IDX_NONBURST_N];

	// ****************************************
	// Reset straps
	// ****************************************
	// latch copy-back strap
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			copyback_bus_mode <= pin_s[bpsc_pkg::IDX_POLICY];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			core_clk_mult <= pin_s[bpsc_pkg::IDX_RATIO] ? bpsc_pkg::MULT_TRIPLE : bpsc_pkg::MULT_DOUBLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		low_voltage_ident_n <= 1'h0;
	end

	// ****************************************
	// Soft reset
	// ****************************************
	// take only at instruction boundary
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			soft_reset_take <= 1'h0;
			soft_serviced   <= 1'h0;
		end else begin
			soft_reset_take <= srst_s & ~soft_serviced & core_instr_boundary;
			soft_serviced   <= srst_s & (soft_serviced | core_instr_boundary);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mgmt_memory_base <= MGMT_BASE_W'(bpsc_pkg::MGMT_BASE_RESET);
		end else if (mgmt_base_wr) begin
			mgmt_memory_base <= mgmt_base_wdata;
		end
	end

	// ****************************************
	// Line fill policy sample
	// ****************************************
	// sample on first ready of fill
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fill_seen         <= 1'h0;
			line_policy_valid <= 1'h0;
			line_write_back   <= 1'h0;
		end else begin
			line_policy_valid <= core_line_fill & ready_s & ~fill_seen;
			fill_seen         <= core_line_fill & (fill_seen | ready_s);
			if (core_line_fill & ready_s & ~fill_seen) begin
				line_write_back <= pin_s[bpsc_pkg::IDX_POLICY];
			end
		end
	end

	// ****************************************
	// Pin state control
	// ****************************************
	always_comb begin
		if (pin_s[bpsc_pkg::IDX_HOLD]) begin
			next_mode = bpsc_pkg::BPSC_BUS_HOLD;
		end else if (core_stop_grant) begin
			next_mode = bpsc_pkg::BPSC_HALT;
		end else if (pin_s[bpsc_pkg::IDX_ADDR_HOLD]) begin
			next_mode = bpsc_pkg::BPSC_ADDR_HOLD;
		end else begin
			next_mode = bpsc_pkg::BPSC_RUN;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode <= bpsc_pkg::BPSC_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hold_ack <= 1'h0;
		end else begin
			hold_ack <= pin_s[bpsc_pkg::IDX_HOLD];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pins_out <= bpsc_pkg::PINS_RESET;
		end else begin
			unique case (next_mode)
				bpsc_pkg::BPSC_HALT: begin
					pins_out.lock_n           <= 1'h1;
					pins_out.pseudo_lock_n    <= 1'h1;
					pins_out.address_strobe_n <= 1'h1;
					pins_out.cacheable_n      <= ~(snoop_s & snoop_hit);
					pins_out.modified_hit_n   <= ~(snoop_s & snoop_hit_modified);
				end
				bpsc_pkg::BPSC_RUN, bpsc_pkg::BPSC_ADDR_HOLD, bpsc_pkg::BPSC_BUS_HOLD: begin
					pins_out <= core_pins;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pins_oe_n <= bpsc_pkg::OE_ALL_DRIVE;
		end else begin
			pins_oe_n <= bpsc_pkg::OE_ALL_DRIVE;
			unique case (next_mode)
				bpsc_pkg::BPSC_BUS_HOLD: begin
					pins_oe_n <= bpsc_pkg::OE_ALL_FLOAT;
				end
				bpsc_pkg::BPSC_ADDR_HOLD: begin
					pins_oe_n.addr_low_bits  <= 1'h1;
					pins_oe_n.cacheable_n    <= 1'h1;
					pins_oe_n.modified_hit_n <= 1'h1;
				end
				bpsc_pkg::BPSC_RUN, bpsc_pkg::BPSC_HALT: begin
				end
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_base_kept_soft: assert property (srst_s && !mgmt_base_wr |=> $stable(mgmt_memory_base))
		else $error("management base changed without a write");

	// bus keeps running during soft reset
	a_bus_runs_soft_reset_in: assert property (srst_s && next_mode == bpsc_pkg::BPSC_RUN
			|=> pins_out == $past(core_pins))
		else $error("bus pins stalled during soft reset");

	a_take_at_boundary: assert property (soft_reset_take |-> $past(core_instr_boundary) ##1 !soft_reset_take)
		else $error("soft reset taken off boundary or repeated");

	// take needs pin high three edges back
	a_soft_reset_in_synced: assert property (soft_reset_take |-> $past(soft_reset_in, 3))
		else $error("soft reset taken without synchronised pin");

	a_copyback_strap: assert property (disable iff (1'b0) rst && $past(rst, 3)
			|=> copyback_bus_mode == $past(pin_s[1]))
		else $error("copy-back strap not latched");

	a_fill_policy_tag: assert property (core_line_fill && ready_s && !fill_seen
			|=> line_policy_valid && line_write_back == $past(pin_s[1]))
		else $error("line policy not sampled on first ready");

	a_ratio_double: assert property (disable iff (1'b0) rst && !pin_s[2] |=> core_clk_mult == 2'h2)
		else $error("core ratio not doubled");

	a_ratio_triple: assert property (disable iff (1'b0) rst && pin_s[2] |=> core_clk_mult == 2'h3)
		else $error("core ratio not tripled");

	a_ident_low: assert property (!$past(rst) |-> !low_voltage_ident_n)
		else $error("identity pin not low");

	// strobes high in halt, ack tracks hold
	a_halt_strobes: assert property (mode == bpsc_pkg::BPSC_HALT
			|-> pins_out.address_strobe_n && pins_out.lock_n && pins_out.pseudo_lock_n)
		else $error("strobe active during halt-grant");

	a_hold_ack_follow: assert property ($rose(pin_s[3]) |=> hold_ack)
		else $error("hold acknowledge did not follow hold");

	a_bus_hold_float: assert property (mode == bpsc_pkg::BPSC_BUS_HOLD |-> pins_oe_n == 10'h3ff)
		else $error("bus group driven in bus hold");

	a_addr_hold_float: assert property (mode == bpsc_pkg::BPSC_ADDR_HOLD
			|-> pins_oe_n.addr_low_bits && !pins_oe_n.byte_enable_n)
		else $error("wrong float set in address hold");

	a_halt_prior: assert property (mode == bpsc_pkg::BPSC_HALT && $past(mode) == bpsc_pkg::BPSC_HALT
			|-> $stable(pins_out.byte_enable_n) && $stable(pins_out.addr_low_bits))
		else $error("held pin changed in halt-grant");

	a_halt_snoop_hit: assert property (next_mode == bpsc_pkg::BPSC_HALT && snoop_s && snoop_hit_modified
			|=> !pins_out.modified_hit_n)
		else $error("modified hit missed in halt-grant");

endmodule : bpsc_top

/* common/bpsc_pkg.sv */
// Purpose: Shared constants and types for the bus pin state and strap control block
// Assumes: One 10 MHz bus clock, synchronous active-high hard reset
// Notes:   Pin vectors are packed structs; output enables are low while driving
//
// Behaviour
// - Soft reset leaves management memory base untouched and never flushes the cache.
// - Soft reset acts like an interrupt; bus cycles continue while it is asserted.
// - A pending soft reset is taken only at an instruction boundary.
// - Soft reset input is asynchronous and is synchronised before use.
// - Line policy pin latched at reset enables copy-back bus mode.
// - First ready of a line fill samples line policy pin to tag the line.
// - Core ratio pin low at reset selects core clock twice bus clock.
// - Core ratio pin high or floating at reset selects triple core clock.
// - Low voltage identity output is driven low at all times.
// - Halt-grant holds listed pins, forces strobes high, hold acknowledge follows hold.
// - Held pins keep driving the level they had before halt-grant.
// - Snoop hits during halt-grant may still assert cacheable and modified-hit pins.
package bpsc_pkg;

	// ****************************************
	// Strap and timing constants
	// ****************************************
	localparam int             SYNC_STAGES     = 2;
	localparam int             MGMT_BASE_W     = 32;
	localparam logic [31:0]    MGMT_BASE_RESET = 32'h0000_0000;
	localparam logic [1:0]     MULT_DOUBLE     = 2'h2;
	localparam logic [1:0]     MULT_TRIPLE     = 2'h3;

	// Bit positions in the synchronised pin vector
	localparam int             PIN_COUNT       = 8;
	localparam int             IDX_SOFT_RESET  = 0;
	localparam int             IDX_POLICY      = 1;
	localparam int             IDX_RATIO       = 2;
	localparam int             IDX_HOLD        = 3;
	localparam int             IDX_ADDR_HOLD   = 4;
	localparam int             IDX_SNOOP_N     = 5;
	localparam int             IDX_BURST_RDY_N = 6;
	localparam int             IDX_NONBURST_N  = 7;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		BPSC_RUN       = 2'h0,
		BPSC_ADDR_HOLD = 2'h1,
		BPSC_BUS_HOLD  = 2'h3,
		BPSC_HALT      = 2'h2
	} bpsc_mode_t;

	typedef struct packed {
		logic       bus_request_out;
		logic [3:0] byte_enable_n;
		logic       page_write_through;
		logic       page_cache_disable;
		logic [2:0] cycle_type;
		logic       lock_n;
		logic       pseudo_lock_n;
		logic       address_strobe_n;
		logic       last_transfer_n;
		logic       parity_error_n;
		logic       fpu_error_n;
		logic [1:0] addr_low_bits;
		logic       mgmt_mode_active_n;
		logic       cacheable_n;
		logic       modified_hit_n;
	} bpsc_bus_pins_t;

	typedef struct packed {
		logic byte_enable_n;
		logic page_attr;
		logic cycle_type;
		logic lock_n;
		logic pseudo_lock_n;
		logic address_strobe_n;
		logic last_transfer_n;
		logic addr_low_bits;
		logic cacheable_n;
		logic modified_hit_n;
	} bpsc_pin_oe_n_t;

	localparam bpsc_bus_pins_t PINS_RESET = '{
		bus_request_out:    1'h0,
		byte_enable_n:      4'hf,
		page_write_through: 1'h0,
		page_cache_disable: 1'h0,
		cycle_type:         3'h0,
		lock_n:             1'h1,
		pseudo_lock_n:      1'h1,
		address_strobe_n:   1'h1,
		last_transfer_n:    1'h1,
		parity_error_n:     1'h1,
		fpu_error_n:        1'h1,
		addr_low_bits:      2'h0,
		mgmt_mode_active_n: 1'h1,
		cacheable_n:        1'h1,
		modified_hit_n:     1'h1
	};
	localparam bpsc_pin_oe_n_t OE_ALL_DRIVE = 10'h000;
	localparam bpsc_pin_oe_n_t OE_ALL_FLOAT = 10'h3ff;

endpackage : bpsc_pkg

/* design/bpsc_sync.sv */
// Purpose: Two flip-flop synchroniser for a vector of independent pin levels
// Assumes: Each bit is a level; bits are not related words
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module bpsc_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	logic [WIDTH-1:0] meta;

	// No reset: straps read these stages during hard reset
	always_ff @(posedge ref_clk) begin
		meta     <= pin_in;
		pin_sync <= meta;
	end

endmodule : bpsc_sync

/* dv/bpsc_sys_model.sv */
// Purpose: System-side pin driver facing the strap and pin-state block
// Assumes: Bench requests pin levels on ref_clk, vector in sync index order
// Notes:   Pins follow requests one edge later; the policy pin holds its level for two edges after hard reset release
`timescale 1ns/1ps
module bpsc_sys_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic [7:0] drive,
	output logic      [7:0] pins
);
	// ****************************************
	// Pin drive
	// ****************************************
	logic [1:0] since_rel;

	always_ff @(posedge ref_clk) begin
		if (rst)
			since_rel <= 2'h0;
		else if (since_rel != 2'h2)
			since_rel <= since_rel + 2'h1;
	end

	always_ff @(posedge ref_clk) begin
		pins <= drive;
		if (!rst && since_rel != 2'h2)
			pins[bpsc_pkg::IDX_POLICY] <= pins[bpsc_pkg::IDX_POLICY];
	end
endmodule : bpsc_sys_model

/* dv/bpsc_top_bench.sv */
// Purpose: Self-checking bench for the strap and pin-state block
// Assumes: System pins come from bpsc_sys_model
// Notes:   Table rows cover pin-state modes; hand tests follow
`timescale 1ns/1ps
module bpsc_top_bench;
	// ****************************************
	// Signals
	// ****************************************
	localparam bpsc_pkg::bpsc_bus_pins_t P = 21'h1a_a8d4;
	logic                     ref_clk = 1'b0;
	logic                     rst     = 1'b1;
	logic [7:0]               drv     = 8'he0;
	logic [7:0]               pin;
	bpsc_pkg::bpsc_bus_pins_t core_pins = P;
	bpsc_pkg::bpsc_bus_pins_t pins_out;
	bpsc_pkg::bpsc_bus_pins_t held;
	bpsc_pkg::bpsc_pin_oe_n_t pins_oe_n;
	logic                     stop = 1'b0, bnd = 1'b0, fill = 1'b0, hit = 1'b0, wr = 1'b0;
	logic [31:0]              wdata = 32'h0000_0000;
	logic [31:0]              base;
	logic                     hold_ack, lvi_n, cb_mode, take, lp_valid, wb;
	logic [1:0]               mult;
	int                       errors = 0, total_checks = 0, takes = 0, i;
	// Rows: hold, addr hold, stop grant, oe_n, hold_ack
	// Halt row follows the run row so its prior levels are the run levels
	logic [13:0]              rows [6] = '{{3'h0, 10'h000, 1'h0}, {3'h1, 10'h000, 1'h0},
		{3'h2, 10'h007, 1'h0}, {3'h4, 10'h3ff, 1'h1}, {3'h5, 10'h3ff, 1'h1}, {3'h6, 10'h3ff, 1'h1}};

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (take === 1'b1) takes++;

	bpsc_sys_model bpsc_sys_model_inst (.ref_clk(ref_clk), .rst(rst), .drive(drv), .pins(pin));

	bpsc_top bpsc_top_inst (
		.ref_clk(ref_clk), .rst(rst), .soft_reset_in(pin[0]), .line_policy_sel_n(pin[1]),
		.core_ratio_sel(pin[2]), .hold(pin[3]), .addr_hold(pin[4]), .snoop_strobe_n(pin[5]),
		.burst_ready_n(pin[6]), .nonburst_ready_n(pin[7]), .core_pins(core_pins),
		.core_stop_grant(stop), .core_instr_boundary(bnd), .core_line_fill(fill),
		.snoop_hit(hit), .snoop_hit_modified(hit), .mgmt_base_wr(wr), .mgmt_base_wdata(wdata),
		.pins_out(pins_out), .pins_oe_n(pins_oe_n), .hold_ack(hold_ack),
		.low_voltage_ident_n(lvi_n), .copyback_bus_mode(cb_mode), .core_clk_mult(mult),
		.soft_reset_take(take), .line_policy_valid(lp_valid), .line_write_back(wb),
		.mgmt_memory_base(base)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run

	task automatic chk1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: bit got %b exp %b", $time, got, exp);
		end
	endtask : chk1

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: word got %h exp %h", $time, got, exp);
		end
	endtask : chk32

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : tick

	task automatic do_reset(input logic pol, input logic rat);
		@(posedge ref_clk);
		rst <= 1'b1;
		drv[1] <= pol;
		drv[2] <= rat;
		tick(20);
		@(posedge ref_clk);
		rst <= 1'b0;
		tick(3);
	endtask : do_reset

	task automatic wait_valid;
		int n;
		n = 0;
		while (lp_valid !== 1'b1 && n < 10) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 10) begin
			errors++;
			$display("ERROR %0t: no line tag", $time);
			complete_run();
		end
	endtask : wait_valid

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		held = P;
		held.lock_n = 1'b1;
		held.pseudo_lock_n = 1'b1;
		held.address_strobe_n = 1'b1;
		held.cacheable_n = 1'b1;
		held.modified_hit_n = 1'b1;
		for (i = 0; i < 2; i++) begin
			do_reset(!i[0], i[0]);
			chk1(cb_mode, !i[0]);
			chk32({30'h0, mult}, {30'h0, i[0] ? bpsc_pkg::MULT_TRIPLE : bpsc_pkg::MULT_DOUBLE});
		end
		$display("test straps done");
		for (i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			drv[3] <= rows[i][13];
			drv[4] <= rows[i][12];
			stop <= rows[i][11];
			core_pins <= rows[i][11] ? ~P : P;
			tick(5);
			chk32({22'h0, pins_oe_n}, {22'h0, rows[i][10:1]});
			chk1(hold_ack, rows[i][0]);
			chk32({11'h0, pins_out}, {11'h0, (rows[i][11] && !rows[i][13]) ? held : core_pins});
			chk1(lvi_n, 1'b0);
		end
		$display("test pin modes done");
		@(posedge ref_clk);
		drv[5:3] <= 3'h0;
		stop <= 1'b1;
		hit <= 1'b1;
		tick(5);
		chk1(pins_out.cacheable_n, 1'b0);
		chk1(pins_out.modified_hit_n, 1'b0);
		@(posedge ref_clk);
		drv[5] <= 1'b1;
		stop <= 1'b0;
		hit <= 1'b0;
		wr <= 1'b1;
		wdata <= 32'h1234_5678;
		@(posedge ref_clk);
		wr <= 1'b0;
		drv[0] <= 1'b1;
		core_pins <= ~P;
		tick(8);
		chk32(32'(takes), 32'h0000_0000);
		chk32({11'h0, pins_out}, {11'h0, ~P});
		@(posedge ref_clk);
		bnd <= 1'b1;
		tick(8);
		chk32(32'(takes), 32'h0000_0001);
		chk32(base, 32'h1234_5678);
		@(posedge ref_clk);
		drv[0] <= 1'b0;
		bnd <= 1'b0;
		$display("test soft reset done");
		@(posedge ref_clk);
		fill <= 1'b1;
		drv[6] <= 1'b0;
		drv[1] <= 1'b1;
		wait_valid();
		chk1(wb, 1'b1);
		@(posedge ref_clk);
		drv[1] <= 1'b0;
		drv[7:6] <= 2'h1;
		tick(5);
		chk1(wb, 1'b1);
		@(posedge ref_clk);
		fill <= 1'b0;
		drv[7] <= 1'b1;
		tick(3);
		@(posedge ref_clk);
		fill <= 1'b1;
		drv[7] <= 1'b0;
		wait_valid();
		chk1(wb, 1'b0);
		$display("test line fill done");
		complete_run();
	end
endmodule : bpsc_top_bench
